/* File: design/b1sfr_top.sv */
// Bank-1 special register map with APB slave, reset columns and counter latch
`timescale 1ns/1ps
module b1sfr_top
   import b1sfr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire b1sfr_rst_t rst_req,
   input wire b1sfr_core_t core_evt,
   input wire b1sfr_periph_t periph,
   output b1sfr_cfg_t cfg,
   output logic [12:0] pc
);
   logic [7:0] reg_r [0:NREG-1];
   logic [7:0] reg_nxt [0:NREG-1];
   logic pready_r;
   logic [31:0] prdata_r;
   logic pslverr_r;
   logic to_r, to_nxt;
   logic pd_r, pd_nxt;
   logic por_n_r, por_n_nxt;
   logic bor_n_r, bor_n_nxt;
   logic ibov_r, ibov_nxt;
   logic [PCH_W-1:0] pc_hi_r, pc_hi_nxt;
   logic [7:0] ram_q;

   // Address decode; only the low index selects storage
   wire [7:0] idx = paddr[9:2];
   wire [4:0] sel = idx[4:0];
   wire in_range = ~|paddr[ADDR_W-1:10];
   wire bank1 = idx[7:5] == BANK1_SEL;
   wire bank0_shared = (idx[7:5] == BANK0_SEL) && SHARED_MASK[sel];
   wire hit = in_range && (bank1 || bank0_shared);
   wire done = psel && penable && pready_r;
   wire rd_take = psel && penable && !pready_r && !pwrite;
   wire wr_hit = done && pwrite && hit;

   // Write strobes for registers with side effects
   wire wr_ind = wr_hit && (sel == OFS_INDIRECT_ACCESS_ALIAS[4:0]);
   wire wr_pcl = wr_hit && (sel == OFS_PROGRAM_COUNTER_LOW[4:0]);
   wire wr_reset_cause_flags = wr_hit && (sel == OFS_RESET_CAUSE_FLAGS[4:0]);
   wire wr_port_e_direction_and_slave_port = wr_hit && (sel == OFS_PORT_E_DIRECTION_AND_SLAVE_PORT[4:0]);

   // Reset cause decode
   wire rst_bor = rst_req.bor;
   wire rst_oth = rst_req.ext_pin || rst_req.wdt;
   wire rst_any = rst_bor || rst_oth;

   // Indirect path; a zero pointer names the alias itself, which holds nothing
   wire [7:0] indirect_pointer = reg_r[OFS_INDIRECT_POINTER[4:0]];
   wire fsr_zero = indirect_pointer == 8'h00;
   wire ram_we = wr_ind && !fsr_zero;
   wire [7:0] ind_rd = fsr_zero ? 8'h00 : ram_q;

   // Hardware-owned bits laid over stored ones; other unused bits stay zero
   wire [7:0] ovl_status = (8'(to_r) << STAT_TO) | (8'(pd_r) << STAT_PD);
   wire [7:0] ovl_port_e_direction_and_slave_port = (8'(periph.ibf) << PORT_E_DIRECTION_AND_SLAVE_PORT_IBF) | (8'(periph.obf) << PORT_E_DIRECTION_AND_SLAVE_PORT_OBF)
                        | (8'(ibov_r) << PORT_E_DIRECTION_AND_SLAVE_PORT_IBOV);
   wire [7:0] ovl_reset_cause_flags = (8'(por_n_r) << RESET_CAUSE_FLAGS_POR) | (8'(bor_n_r) << RESET_CAUSE_FLAGS_BOR);
   wire [7:0] ovl_uart_tx_control_status = 8'(periph.trmt) << UART_TX_CONTROL_STATUS_TRMT;
   wire [7:0] ovl_ssp = {2'h0, periph.ssp};
   wire [7:0] ovl =
      (sel == OFS_CORE_STATUS_FLAGS[4:0]) ? ovl_status :
      (sel == OFS_PORT_E_DIRECTION_AND_SLAVE_PORT[4:0]) ? ovl_port_e_direction_and_slave_port :
      (sel == OFS_RESET_CAUSE_FLAGS[4:0]) ? ovl_reset_cause_flags :
      (sel == OFS_UART_TX_CONTROL_STATUS[4:0]) ? ovl_uart_tx_control_status :
      (sel == OFS_SERIAL_PORT_STATE[4:0]) ? ovl_ssp : 8'h00;
   wire [7:0] reg_rd = (sel == OFS_INDIRECT_ACCESS_ALIAS[4:0]) ? ind_rd : (reg_r[sel] | ovl);
   wire [7:0] rd_val = hit ? reg_rd : 8'h00;

   // Plain storage, one slot per low index; unused slots fold to constants
   for (genvar g = 0; g < NREG; g++) begin : g_reg
      wire wsel = wr_hit && (sel == 5'(g));
      wire [7:0] oth_val = (reg_r[g] & KEEP_OTH[g]) | (RST_VAL[g] & ~KEEP_OTH[g]);
      assign reg_nxt[g] = rst_bor ? RST_VAL[g] :
                          rst_oth ? oth_val :
                          wsel ? (pwdata[7:0] & WMASK[g]) : reg_r[g];
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            reg_r[g] <= RST_VAL[g];
         end else begin
            reg_r[g] <= reg_nxt[g];
         end
      end
   end

   // Timeout and sleep flags follow the reset cause and core events
   assign to_nxt = rst_bor ? 1'b1 :
                   rst_req.wdt ? 1'b0 :
                   rst_req.ext_pin ? to_r :
                   (core_evt.sleep || core_evt.clrwdt) ? 1'b1 : to_r;
   assign pd_nxt = rst_bor ? 1'b1 :
                   rst_oth ? pd_r :
                   core_evt.sleep ? 1'b0 :
                   core_evt.clrwdt ? 1'b1 : pd_r;

   // Reset cause flags: cleared by their cause, set again by software
   assign por_n_nxt = rst_any ? por_n_r : (wr_reset_cause_flags ? pwdata[RESET_CAUSE_FLAGS_POR] : por_n_r);
   assign bor_n_nxt = rst_bor ? 1'b0 : rst_oth ? bor_n_r :
                      (wr_reset_cause_flags ? pwdata[RESET_CAUSE_FLAGS_BOR] : bor_n_r);

   // Overflow flag: a set in the clearing cycle wins
   assign ibov_nxt = rst_any ? 1'b0 :
                     periph.ibov_set || (wr_port_e_direction_and_slave_port ? pwdata[PORT_E_DIRECTION_AND_SLAVE_PORT_IBOV] : ibov_r);

   // Upper counter bits are only reachable through the latch
   assign pc_hi_nxt = rst_any ? '0 :
                      wr_pcl ? reg_r[OFS_UPPER_PC_LATCH[4:0]][PCH_W-1:0] : pc_hi_r;

   // Core-side flags; power-on clears the reset cause bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         to_r <= 1'b1;
         pd_r <= 1'b1;
         por_n_r <= 1'b0;
         bor_n_r <= 1'b0;
         ibov_r <= 1'b0;
         pc_hi_r <= '0;
      end else begin
         to_r <= to_nxt;
         pd_r <= pd_nxt;
         por_n_r <= por_n_nxt;
         bor_n_r <= bor_n_nxt;
         ibov_r <= ibov_nxt;
         pc_hi_r <= pc_hi_nxt;
      end
   end

   // APB answer: one wait state so the memory read data can settle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else begin
         pready_r <= psel && penable && !pready_r;
         if (rd_take) begin
            prdata_r <= {24'h00_0000, rd_val};
         end
      end
   end

   b1sfr_ram u_ram (
      .clk(pclk),
      .we(ram_we),
      .waddr(indirect_pointer),
      .wdata(pwdata[7:0]),
      .raddr(indirect_pointer),
      .rdata_r(ram_q)
   );

   // Outputs are taken directly from the register flops
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign pc = {pc_hi_r, reg_r[OFS_PROGRAM_COUNTER_LOW[4:0]]};
   assign cfg.option = reg_r[OFS_TIMER0_AND_PULLUP_CONFIG[4:0]];
   assign cfg.tris_a = reg_r[OFS_PORT_A_DIRECTION[4:0]];
   assign cfg.tris_b = reg_r[OFS_PORT_B_DIRECTION[4:0]];
   assign cfg.tris_c = reg_r[OFS_PORT_C_DIRECTION[4:0]];
   assign cfg.tris_d = reg_r[OFS_PORT_D_DIRECTION[4:0]];
   assign cfg.tris_e = reg_r[OFS_PORT_E_DIRECTION_AND_SLAVE_PORT[4:0]];
   assign cfg.intctl = reg_r[OFS_CORE_INTERRUPT_CONTROL[4:0]];
   assign cfg.peripheral_irq_enable_1 = reg_r[OFS_PERIPHERAL_IRQ_ENABLE_1[4:0]];
   assign cfg.peripheral_irq_enable_2 = reg_r[OFS_PERIPHERAL_IRQ_ENABLE_2[4:0]];
   assign cfg.pr2 = reg_r[OFS_TIMER2_PERIOD[4:0]];
   assign cfg.serial_port_slave_address = reg_r[OFS_SERIAL_PORT_SLAVE_ADDRESS[4:0]];
   assign cfg.txctl = reg_r[OFS_UART_TX_CONTROL_STATUS[4:0]];
   assign cfg.baud = reg_r[OFS_BAUD_DIVISOR[4:0]];
   assign cfg.adcfg = reg_r[OFS_CONVERTER_PIN_CONFIG[4:0]];
   assign cfg.status = reg_r[OFS_CORE_STATUS_FLAGS[4:0]];
   assign cfg.pointer = indirect_pointer;

   // Checks on the register behaviour
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_unmapped_reads_zero: assert property (
      (psel && penable && !pwrite && !pready_r && !hit) |=> (pready_r && prdata_r == 32'h0))
      else $error("unmapped read returned nonzero data");
   chk_latch_upper_bits_zero: assert property (
      (rd_take && hit && sel == OFS_UPPER_PC_LATCH[4:0]) |=> (prdata_r[7:PCH_W] == 3'h0))
      else $error("unused latch bits read nonzero");
   chk_pc_high_hidden: assert property (
      !$stable(pc_hi_r) |-> ($past(wr_pcl) || $past(rst_any)))
      else $error("upper counter changed without a low byte write");
   chk_latch_copy: assert property (
      (wr_pcl && !rst_any) |=> (pc[12:8] == $past(reg_r[OFS_UPPER_PC_LATCH[4:0]][4:0])))
      else $error("latch not copied into upper counter");
   chk_pointer_kept: assert property (
      (rst_req.ext_pin && !rst_bor) |=> (cfg.pointer == $past(indirect_pointer) && pd_r == $past(pd_r)))
      else $error("unchanged bits lost over pin reset");
   chk_wdt_flags: assert property (
      (rst_req.wdt && !rst_bor) |=> (!to_r && bor_n_r == $past(bor_n_r)))
      else $error("watchdog reset left timeout flag set");
   chk_first_column: assert property (
      rst_bor |=> (cfg.option == 8'hff && cfg.tris_a == 8'h3f && to_r && pd_r && !bor_n_r))
      else $error("brown-out did not load first column");
   chk_shared_alias: assert property (
      (wr_hit && idx == 8'h0a && !rst_any) |=> (reg_r[10] == ($past(pwdata[7:0]) & 8'h1f)))
      else $error("first-bank alias of latch not written");
   chk_second_column: assert property (
      (rst_oth && !rst_bor) |=> (cfg.tris_e == 8'h07 && pc_hi_r == 5'h00
                                  && por_n_r == $past(por_n_r)))
      else $error("pin or watchdog reset did not load second column");

   cov_indirect_read: cover property (rd_take && hit && sel == 5'h00 && !fsr_zero);
   cov_bank0_write: cover property (wr_hit && idx[7:5] == BANK0_SEL);
   cov_wdt_reset: cover property (rst_req.wdt);
   cov_pcl_jump: cover property (wr_pcl && reg_r[10] != 8'h00);
endmodule : b1sfr_top

/* File: pkg/b1sfr_pkg.sv */
// Package for the bank-1 special register map: offsets, layouts, reset tables, carriers
package b1sfr_pkg;
   localparam int ADDR_W = 12;
   localparam int NREG = 32;
   localparam int RAM_AW = 8;
   localparam logic [2:0] BANK1_SEL = 3'h4;
   localparam logic [2:0] BANK0_SEL = 3'h0;
   // Printed offsets; bus byte address is four times the offset
   localparam logic [7:0] OFS_INDIRECT_ACCESS_ALIAS = 8'h80;
   localparam logic [7:0] OFS_TIMER0_AND_PULLUP_CONFIG = 8'h81;
   localparam logic [7:0] OFS_PROGRAM_COUNTER_LOW = 8'h82;
   localparam logic [7:0] OFS_CORE_STATUS_FLAGS = 8'h83;
   localparam logic [7:0] OFS_INDIRECT_POINTER = 8'h84;
   localparam logic [7:0] OFS_PORT_A_DIRECTION = 8'h85;
   localparam logic [7:0] OFS_PORT_B_DIRECTION = 8'h86;
   localparam logic [7:0] OFS_PORT_C_DIRECTION = 8'h87;
   localparam logic [7:0] OFS_PORT_D_DIRECTION = 8'h88;
   localparam logic [7:0] OFS_PORT_E_DIRECTION_AND_SLAVE_PORT = 8'h89;
   localparam logic [7:0] OFS_UPPER_PC_LATCH = 8'h8a;
   localparam logic [7:0] OFS_CORE_INTERRUPT_CONTROL = 8'h8b;
   localparam logic [7:0] OFS_PERIPHERAL_IRQ_ENABLE_1 = 8'h8c;
   localparam logic [7:0] OFS_PERIPHERAL_IRQ_ENABLE_2 = 8'h8d;
   localparam logic [7:0] OFS_RESET_CAUSE_FLAGS = 8'h8e;
   localparam logic [7:0] OFS_TIMER2_PERIOD = 8'h92;
   localparam logic [7:0] OFS_SERIAL_PORT_SLAVE_ADDRESS = 8'h93;
   localparam logic [7:0] OFS_SERIAL_PORT_STATE = 8'h94;
   localparam logic [7:0] OFS_UART_TX_CONTROL_STATUS = 8'h98;
   localparam logic [7:0] OFS_BAUD_DIVISOR = 8'h99;
   localparam logic [7:0] OFS_CONVERTER_PIN_CONFIG = 8'h9f;
   // Registers mirrored into the first bank, one bit per low index
   localparam logic [31:0] SHARED_MASK = 32'h0000_0c1d;
   // Field positions of hardware-owned bits
   localparam int STAT_TO = 4;
   localparam int STAT_PD = 3;
   localparam int PORT_E_DIRECTION_AND_SLAVE_PORT_IBF = 7;
   localparam int PORT_E_DIRECTION_AND_SLAVE_PORT_OBF = 6;
   localparam int PORT_E_DIRECTION_AND_SLAVE_PORT_IBOV = 5;
   localparam int RESET_CAUSE_FLAGS_POR = 1;
   localparam int RESET_CAUSE_FLAGS_BOR = 0;
   localparam int UART_TX_CONTROL_STATUS_TRMT = 1;
   localparam int PCH_W = 5;
   // Software-writable bits per low index
   localparam logic [7:0] WMASK [0:31] = '{
      8'h00, 8'hff, 8'hff, 8'he7, 8'hff, 8'h3f, 8'hff, 8'hff,
      8'hff, 8'h17, 8'h1f, 8'hff, 8'hff, 8'h01, 8'h00, 8'h00,
      8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00,
      8'hf5, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h07};
   // Reset values; unknown bits are taken as zero
   localparam logic [7:0] RST_VAL [0:31] = '{
      8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h3f, 8'hff, 8'hff,
      8'hff, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   // Bits left unchanged by a pin or watchdog reset
   localparam logic [7:0] KEEP_OTH [0:31] = '{
      8'h00, 8'h00, 8'h00, 8'h07, 8'hff, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

   typedef struct packed {
      logic bor;
      logic ext_pin;
      logic wdt;
   } b1sfr_rst_t;
   typedef struct packed {
      logic sleep;
      logic clrwdt;
   } b1sfr_core_t;
   typedef struct packed {
      logic ibf;
      logic obf;
      logic ibov_set;
      logic trmt;
      logic [5:0] ssp;
   } b1sfr_periph_t;
   typedef struct packed {
      logic [7:0] option;
      logic [7:0] tris_a;
      logic [7:0] tris_b;
      logic [7:0] tris_c;
      logic [7:0] tris_d;
      logic [7:0] tris_e;
      logic [7:0] intctl;
      logic [7:0] peripheral_irq_enable_1;
      logic [7:0] peripheral_irq_enable_2;
      logic [7:0] pr2;
      logic [7:0] serial_port_slave_address;
      logic [7:0] txctl;
      logic [7:0] baud;
      logic [7:0] adcfg;
      logic [7:0] status;
      logic [7:0] pointer;
   } b1sfr_cfg_t;
endpackage : b1sfr_pkg

/* File: design/b1sfr_ram.sv */
// Data memory reached through the indirect access alias
`timescale 1ns/1ps
module b1sfr_ram
   import b1sfr_pkg::*;
(
   input wire logic clk,
   input wire logic we,
   input wire logic [RAM_AW-1:0] waddr,
   input wire logic [7:0] wdata,
   input wire logic [RAM_AW-1:0] raddr,
   output logic [7:0] rdata_r
);
   logic [7:0] mem [0:(1<<RAM_AW)-1];

   // No reset on the array; read data always comes from a register
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata_r <= mem[raddr];
   end
endmodule : b1sfr_ram

/* File: tb/b1sfr_tb.sv */
// Self-checking bench for the bank-1 special register map over APB
`timescale 1ns/1ps
module b1sfr_tb
   import b1sfr_pkg::*;
;
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   b1sfr_rst_t rst_req;
   b1sfr_core_t core_evt;
   b1sfr_periph_t periph;
   b1sfr_cfg_t cfg;
   logic [12:0] pc;
   int err_count;
   int check_count;
   int i;
   logic [7:0] lf;
   logic [7:0] e;
   logic [7:0] eq[$];
   logic [7:0] mq[$];

   b1sfr_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rst_req(rst_req), .core_evt(core_evt), .periph(periph),
      .cfg(cfg), .pc(pc));

   // Pseudo-random byte source, fixed start so failures replay
   function automatic logic [7:0] lfsr_next(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction : lfsr_next

   task automatic cmp(input string nm, input logic [31:0] x, input logic [31:0] s);
      check_count++;
      if (s !== x) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, x, s);
      end
   endtask : cmp

   // One APB transfer; an idle edge first keeps psel from being set twice in a step
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [7:0] idx, input logic [7:0] x, input logic [7:0] m);
      eq.push_back(x);
      mq.push_back(m);
      apb(1'b0, idx, 8'h00);
   endtask : rd

   task automatic pulse(input b1sfr_rst_t r);
      @(posedge pclk);
      rst_req <= r;
      @(posedge pclk);
      rst_req <= '0;
      repeat (2) @(posedge pclk);
   endtask : pulse

   task give_verdict;
      $display("Mismatches %0d, comparisons %0d", err_count, check_count);
      if (err_count == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict

   // Clock, 100 ns period
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   // Read checker: oldest expectation against data taken at the pready edge
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && pwrite === 1'b0) begin
         cmp("slave error", 32'h0, {31'h0, pslverr});
         if (eq.size() == 0)
            cmp("unexpected read", 32'h1, 32'h0);
         else
            cmp("read data", {24'h0, eq.pop_front()}, prdata & {24'hffffff, mq.pop_front()});
      end
   end

   // Watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge pclk);
      err_count++;
      give_verdict();
   end

   // Main sequence
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      rst_req = '0;
      core_evt = '0;
      periph = '0;
      lf = 8'h54;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      periph.ssp <= lf[5:0];
      @(negedge pclk);
      cmp("cfg reset", 32'hff3fffff, {cfg.option, cfg.tris_a, cfg.tris_b, cfg.tris_c});
      cmp("cfg reset2", 32'hff07ff00, {cfg.tris_d, cfg.tris_e, cfg.pr2, cfg.peripheral_irq_enable_1});
      rd(8'h83, 8'h18, 8'hff);
      rd(8'h8e, 8'h00, 8'hff);
      // Walk the bank from 0x81 to 0x9f except 0x8e, holes included; unused bits must come back clear
      for (i = 8'h81; i <= 8'h9f; i++) begin
         if (i != 8'h8e) begin
            lf = lfsr_next(lf);
            e = (lf & WMASK[i[4:0]]) | ((i == 8'h83) ? 8'h18 : 8'h00);
            e = e | ((i == 8'h94) ? {2'b00, periph.ssp} : 8'h00);
            apb(1'b1, i[7:0], lf);
            rd(i[7:0], e, (i == 8'h89) ? 8'hdf : 8'hff);
         end
      end
      apb(1'b1, 8'h8a, 8'h13);
      apb(1'b1, 8'h82, 8'hc5);
      @(negedge pclk);
      cmp("pc", 32'h13c5, {19'h0, pc});
      apb(1'b1, 8'h04, 8'h5a);
      rd(8'h84, 8'h5a, 8'hff);
      // First-bank alias of the latch; a non-shared first-bank slot stays empty
      apb(1'b1, 8'h0a, 8'h3c);
      rd(8'h8a, 8'h1c, 8'hff);
      apb(1'b1, 8'h01, 8'ha5);
      rd(8'h01, 8'h00, 8'hff);
      apb(1'b1, 8'h81, 8'h00);
      @(posedge pclk);
      core_evt.sleep <= 1'b1;
      @(posedge pclk);
      core_evt <= '0;
      rd(8'h83, 8'h10, 8'h18);
      pulse(b1sfr_rst_t'(3'b010));
      rd(8'h84, 8'h5a, 8'hff);
      rd(8'h81, 8'hff, 8'hff);
      rd(8'h83, 8'h10, 8'h18);
      cmp("pc after pin reset", 32'h0, {19'h0, pc});
      @(posedge pclk);
      core_evt.clrwdt <= 1'b1;
      @(posedge pclk);
      core_evt <= '0;
      rd(8'h83, 8'h18, 8'h18);
      pulse(b1sfr_rst_t'(3'b001));
      rd(8'h83, 8'h08, 8'h18);
      apb(1'b1, 8'h8e, 8'h03);
      rd(8'h8e, 8'h03, 8'hff);
      pulse(b1sfr_rst_t'(3'b100));
      rd(8'h8e, 8'h02, 8'hff);
      rd(8'h84, 8'h00, 8'hff);
      rd(8'h83, 8'h18, 8'h18);
      // Second power-on reset in mid-run clears the cause flags
      @(posedge pclk);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      rd(8'h8e, 8'h00, 8'hff);
      rd(8'h81, 8'hff, 8'hff);
      give_verdict();
   end
endmodule : b1sfr_tb
